// *** logic/ulf_pkg.sv ***
package ulf_pkg;

  // ***************************************
  // Register offsets (byte addresses)
  // ***************************************
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_IER = 8'h04;
  localparam logic [7:0] OFS_LFC = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h14;

  // ***************************************
  // Line format control fields
  // ***************************************
  localparam int LFC_DIV_ACC = 7;
  localparam int LFC_BREAK = 6;
  localparam int LFC_STICK = 5;
  localparam int LFC_EVEN = 4;
  localparam int LFC_PAR_EN = 3;
  localparam int LFC_STOP = 2;
  localparam int LFC_LEN_HI = 1;
  localparam int LFC_LEN_LO = 0;
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [1:0] LEN_5BIT = 2'h0;
  localparam logic [1:0] LEN_8BIT = 2'h3;

  // ***************************************
  // Status fields and other resets
  // ***************************************
  localparam int ST_RX_READY = 0;
  localparam int ST_PAR_ERR = 2;
  localparam int ST_FRM_ERR = 3;
  localparam int ST_THR_EMPTY = 5;
  localparam int ST_TX_IDLE = 6;
  localparam logic [3:0] IER_RESET = 4'h0;
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // ***************************************
  // Bit timing in 16x ticks
  // ***************************************
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_STOP_1P5 = 6'h18;
  localparam logic [5:0] TICKS_STOP_2 = 6'h20;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PARITY,
    ST_STOP
  } ulf_state_t;

  // Mask of the data bits in use for a length code
  function automatic logic [7:0] len_mask(input logic [1:0] len);
    len_mask = 8'hff >> (2'h3 - len);
  endfunction

  // Parity bit that is sent, and expected on receive
  function automatic logic par_bit(input logic [7:0] data, input logic [7:0] lfc);
    logic ones;
    ones = ^(data & len_mask(lfc[LFC_LEN_HI:LFC_LEN_LO]));
    if (lfc[LFC_STICK]) begin
      par_bit = ~lfc[LFC_EVEN];
    end else if (lfc[LFC_EVEN]) begin
      par_bit = ones;
    end else begin
      par_bit = ~ones;
    end
  endfunction

endpackage

// *** logic/ulf_baud_tick.sv ***
// ***************************************
// 16x sample tick from the divisor
// ***************************************
module ulf_baud_tick #(
  parameter int DIV_W = 16
) (
  input wire logic ref_clk, // Port clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [DIV_W-1:0] divisor, // Divisor latch value
  output logic tick // One-cycle 16x pulse
);

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic tick_nxt;
  logic run;

  if (DIV_W < 2) begin : g_chk
    $error("ulf_baud_tick: DIV_W must be at least 2");
  end

  // Divisor of zero stops the tick
  assign run = (divisor != '0);
  assign tick_nxt = run && (cnt_r >= divisor - 1'b1);
  assign cnt_nxt = (!run || tick_nxt) ? '0 : cnt_r + 1'b1;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end

endmodule

// *** logic/ulf_line_format.sv ***
module ulf_line_format #(
  parameter int DIV_W = 16
) (
  input wire logic ref_clk, // Port clock, 250 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic [7:0] addr, // Register byte address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic serial_rx_line, // Serial input pin
  output logic serial_tx_line // Serial output pin
);

  // ***************************************
  // Parameter check
  // ***************************************
  if (DIV_W < 2 || DIV_W > 16) begin : g_chk
    $error("ulf_line_format: DIV_W must be 2 to 16");
  end

  // ***************************************
  // Registers
  // ***************************************
  logic [7:0] lfc_r;
  logic [3:0] ier_r;
  logic [15:0] div_r;
  logic [7:0] thr_r;
  logic thr_full_r;
  logic [7:0] rbr_r;
  logic rx_ready_r;
  logic par_err_r;
  logic frm_err_r;

  // ***************************************
  // Address decode
  // ***************************************
  logic div_acc;
  logic hit_data;
  logic hit_ier;
  logic hit_lfc;
  logic hit_stat;
  logic wr_thr;
  logic wr_ier;
  logic wr_dll;
  logic wr_dlm;
  logic wr_lfc;
  logic rd_rbr;
  logic rd_stat;

  assign div_acc = lfc_r[ulf_pkg::LFC_DIV_ACC];
  assign hit_data = (addr == ulf_pkg::OFS_DATA);
  assign hit_ier = (addr == ulf_pkg::OFS_IER);
  assign hit_lfc = (addr == ulf_pkg::OFS_LFC);
  assign hit_stat = (addr == ulf_pkg::OFS_STAT);

  assign wr_dll = wr && hit_data && div_acc;
  assign wr_dlm = wr && hit_ier && div_acc;
  assign wr_thr = wr && hit_data && !div_acc;
  assign wr_ier = wr && hit_ier && !div_acc;
  assign rd_rbr = rd && hit_data && !div_acc;
  assign wr_lfc = wr && hit_lfc;
  assign rd_stat = rd && hit_stat;

  // ***************************************
  // Baud tick
  // ***************************************
  logic tick;

  ulf_baud_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .divisor(div_r[DIV_W-1:0]),
    .tick(tick)
  );

  // ***************************************
  // Frame format decode
  // ***************************************
  logic [1:0] len;
  logic [2:0] last_idx;
  logic par_en;
  logic [5:0] stop_ticks;

  // Length code to last bit index
  assign len = lfc_r[ulf_pkg::LFC_LEN_HI:ulf_pkg::LFC_LEN_LO];
  assign last_idx = {1'b1, len} - 3'h4 + 3'h4;
  assign par_en = lfc_r[ulf_pkg::LFC_PAR_EN];

  assign stop_ticks = !lfc_r[ulf_pkg::LFC_STOP] ? ulf_pkg::TICKS_BIT :
                      (len == ulf_pkg::LEN_5BIT) ? ulf_pkg::TICKS_STOP_1P5 :
                      ulf_pkg::TICKS_STOP_2;

  // ***************************************
  // Register writes
  // ***************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lfc_r <= ulf_pkg::LFC_RESET;
      ier_r <= ulf_pkg::IER_RESET;
      div_r <= ulf_pkg::DIV_RESET;
      thr_r <= 8'h00;
    end else begin
      if (wr_lfc) begin
        lfc_r <= wdata;
      end
      if (wr_ier) begin
        ier_r <= wdata[3:0];
      end
      if (wr_dll) begin
        div_r[7:0] <= wdata;
      end
      if (wr_dlm) begin
        div_r[15:8] <= wdata;
      end
      if (wr_thr) begin
        thr_r <= wdata;
      end
    end
  end

  // ***************************************
  // Transmitter
  // ***************************************
  ulf_pkg::ulf_state_t tx_st_r;
  ulf_pkg::ulf_state_t tx_st_nxt;
  logic [5:0] tx_cnt_r;
  logic [5:0] tx_cnt_nxt;
  logic [2:0] tx_idx_r;
  logic [7:0] tx_sh_r;
  logic tx_par_r;
  logic tx_load;
  logic tx_bit_end;
  logic tx_stop_end;
  logic tx_level;
  logic tx_idle;
  logic tx_in_stop;
  logic tx_cnt_clr;

  assign tx_idle = (tx_st_r == ulf_pkg::ST_IDLE);
  assign tx_in_stop = (tx_st_r == ulf_pkg::ST_STOP);
  assign tx_load = tx_idle && thr_full_r;
  assign tx_bit_end = tick && (tx_cnt_r == ulf_pkg::TICKS_BIT - 6'h01);
  assign tx_stop_end = tick && (tx_cnt_r == stop_ticks - 6'h01);
  // Stop may run past one bit time, so only its own end clears it
  assign tx_cnt_clr = tx_idle || (tx_in_stop ? tx_stop_end : tx_bit_end);
  assign tx_cnt_nxt = tx_cnt_clr ? 6'h00 :
                      tick ? tx_cnt_r + 6'h01 : tx_cnt_r;

  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      ulf_pkg::ST_IDLE: begin
        if (tx_load) begin
          tx_st_nxt = ulf_pkg::ST_START;
        end
      end
      ulf_pkg::ST_START: begin
        if (tx_bit_end) begin
          tx_st_nxt = ulf_pkg::ST_DATA;
        end
      end
      ulf_pkg::ST_DATA: begin
        // Parity goes after the last data bit
        if (tx_bit_end && tx_idx_r == last_idx) begin
          tx_st_nxt = par_en ? ulf_pkg::ST_PARITY : ulf_pkg::ST_STOP;
        end
      end
      ulf_pkg::ST_PARITY: begin
        if (tx_bit_end) begin
          tx_st_nxt = ulf_pkg::ST_STOP;
        end
      end
      ulf_pkg::ST_STOP: begin
        if (tx_stop_end) begin
          tx_st_nxt = ulf_pkg::ST_IDLE;
        end
      end
      default: begin
        tx_st_nxt = ulf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_r <= ulf_pkg::ST_IDLE;
      tx_cnt_r <= 6'h00;
      tx_idx_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      if (tx_load) begin
        tx_sh_r <= thr_r;
        tx_idx_r <= 3'h0;
        tx_par_r <= ulf_pkg::par_bit(thr_r, lfc_r);
      end else if (tx_st_r == ulf_pkg::ST_DATA && tx_bit_end) begin
        tx_sh_r <= {1'b0, tx_sh_r[7:1]};
        tx_idx_r <= tx_idx_r + 3'h1;
      end
    end
  end

  // Holding register: a new write wins over the load that empties it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      thr_full_r <= 1'b0;
    end else if (wr_thr) begin
      thr_full_r <= 1'b1;
    end else if (tx_load) begin
      thr_full_r <= 1'b0;
    end
  end

  always_comb begin
    case (tx_st_r)
      ulf_pkg::ST_START: tx_level = 1'b0;
      ulf_pkg::ST_DATA: tx_level = tx_sh_r[0];
      ulf_pkg::ST_PARITY: tx_level = tx_par_r;
      default: tx_level = 1'b1;
    endcase
  end

  // Break gates only the pin, so the shifter keeps running underneath
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_tx_line <= 1'b1;
    end else begin
      serial_tx_line <= tx_level && !lfc_r[ulf_pkg::LFC_BREAK];
    end
  end

  // ***************************************
  // Receiver
  // ***************************************
  logic rx_s1_r;
  logic rx_s2_r;
  ulf_pkg::ulf_state_t rx_st_r;
  ulf_pkg::ulf_state_t rx_st_nxt;
  logic [5:0] rx_cnt_r;
  logic [2:0] rx_idx_r;
  logic [7:0] rx_sh_r;
  logic rx_mid;
  logic rx_smp;
  logic [7:0] rx_word;
  logic rx_done;
  logic rx_par_bad;

  assign rx_mid = tick && (rx_cnt_r == ulf_pkg::TICKS_HALF - 6'h01);
  assign rx_smp = tick && (rx_cnt_r == ulf_pkg::TICKS_BIT - 6'h01);
  assign rx_word = rx_sh_r >> (2'h3 - len);
  // Only the first stop bit is sampled
  assign rx_done = (rx_st_r == ulf_pkg::ST_STOP) && rx_smp;
  assign rx_par_bad = (rx_st_r == ulf_pkg::ST_PARITY) && rx_smp &&
                      (rx_s2_r != ulf_pkg::par_bit(rx_word, lfc_r));

  always_comb begin
    rx_st_nxt = rx_st_r;
    case (rx_st_r)
      ulf_pkg::ST_IDLE: begin
        if (tick && !rx_s2_r) begin
          rx_st_nxt = ulf_pkg::ST_START;
        end
      end
      ulf_pkg::ST_START: begin
        if (rx_mid) begin
          rx_st_nxt = rx_s2_r ? ulf_pkg::ST_IDLE : ulf_pkg::ST_DATA;
        end
      end
      ulf_pkg::ST_DATA: begin
        if (rx_smp && rx_idx_r == last_idx) begin
          rx_st_nxt = par_en ? ulf_pkg::ST_PARITY : ulf_pkg::ST_STOP;
        end
      end
      ulf_pkg::ST_PARITY: begin
        if (rx_smp) begin
          rx_st_nxt = ulf_pkg::ST_STOP;
        end
      end
      ulf_pkg::ST_STOP: begin
        if (rx_smp) begin
          rx_st_nxt = ulf_pkg::ST_IDLE;
        end
      end
      default: begin
        rx_st_nxt = ulf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_st_r <= ulf_pkg::ST_IDLE;
      rx_cnt_r <= 6'h00;
      rx_idx_r <= 3'h0;
      rx_sh_r <= 8'h00;
    end else begin
      rx_s1_r <= serial_rx_line;
      rx_s2_r <= rx_s1_r;
      rx_st_r <= rx_st_nxt;
      if (rx_st_r == ulf_pkg::ST_IDLE || rx_mid && rx_st_r == ulf_pkg::ST_START || rx_smp) begin
        rx_cnt_r <= 6'h00;
      end else if (tick) begin
        rx_cnt_r <= rx_cnt_r + 6'h01;
      end
      if (rx_st_r == ulf_pkg::ST_START) begin
        rx_idx_r <= 3'h0;
      end else if (rx_st_r == ulf_pkg::ST_DATA && rx_smp) begin
        rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
        rx_idx_r <= rx_idx_r + 3'h1;
      end
    end
  end

  // New events win over the read that clears them
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rbr_r <= 8'h00;
      rx_ready_r <= 1'b0;
      par_err_r <= 1'b0;
      frm_err_r <= 1'b0;
    end else begin
      if (rx_done) begin
        rbr_r <= rx_word;
      end
      rx_ready_r <= rx_done || (rx_ready_r && !rd_rbr);
      par_err_r <= rx_par_bad || (par_err_r && !rd_stat);
      frm_err_r <= (rx_done && !rx_s2_r) || (frm_err_r && !rd_stat);
    end
  end

  // ***************************************
  // Read mux
  // ***************************************
  logic [7:0] stat;
  logic [7:0] data_rd;
  logic [7:0] ier_rd;
  logic [7:0] rd_mux;

  assign stat = (8'h01 << ulf_pkg::ST_RX_READY) & {8{rx_ready_r}} |
                (8'h01 << ulf_pkg::ST_PAR_ERR) & {8{par_err_r}} |
                (8'h01 << ulf_pkg::ST_FRM_ERR) & {8{frm_err_r}} |
                (8'h01 << ulf_pkg::ST_THR_EMPTY) & {8{!thr_full_r}} |
                (8'h01 << ulf_pkg::ST_TX_IDLE) & {8{tx_idle && !thr_full_r}};
  assign data_rd = div_acc ? div_r[7:0] : rbr_r;
  assign ier_rd = div_acc ? div_r[15:8] : {4'h0, ier_r};
  assign rd_mux = hit_data ? data_rd :
                  hit_ier ? ier_rd :
                  hit_lfc ? lfc_r :
                  hit_stat ? stat : 8'h00;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

endmodule

// *** dv/ulf_line_format_checker.sv ***
// ****************
// Port checker
// ****************
module ulf_line_format_checker #(
  parameter int DIV_W = 16
) (
  input logic ref_clk, // Port clock
  input logic arst_n, // Async reset, active low
  input logic [7:0] addr, // Register address
  input logic [7:0] wdata, // Write data
  input logic wr, // Write strobe
  input logic rd, // Read strobe
  input logic [7:0] rdata, // Read data
  input logic serial_rx_line, // Serial input
  input logic serial_tx_line // Serial output
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  logic [7:0] lfc_r, dlo_r, dhi_r, exp_r;
  logic [3:0] ier_r;
  logic [2:0] kind_r;
  logic quiet_r;
  wire dla = lfc_r[ulf_pkg::LFC_DIV_ACC];
  wire a_lfc = addr == ulf_pkg::OFS_LFC;
  wire a_dat = addr == ulf_pkg::OFS_DATA;
  wire a_ier = addr == ulf_pkg::OFS_IER;
  wire a_unm = !(a_lfc || a_dat || a_ier || addr == ulf_pkg::OFS_STAT);
  // Shadow decode mirrors the register map seen by software
  wire [2:0] kind_w = a_lfc ? 3'h1 : (a_dat && dla) ? 3'h2 : a_ier ? (dla ? 3'h3 : 3'h4) : 3'h6;
  wire [7:0] exp_w = kind_w == 3'h1 ? lfc_r : kind_w == 3'h2 ? dlo_r :
    kind_w == 3'h3 ? dhi_r : {4'h0, ier_r};
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lfc_r <= ulf_pkg::LFC_RESET;
      dlo_r <= ulf_pkg::DIV_RESET[7:0];
      dhi_r <= ulf_pkg::DIV_RESET[15:8];
      ier_r <= ulf_pkg::IER_RESET;
      kind_r <= 3'h0;
      exp_r <= 8'h00;
      quiet_r <= 1'b1;
    end else begin
      if (wr && a_lfc) lfc_r <= wdata;
      if (wr && a_dat && dla) dlo_r <= wdata;
      if (wr && a_ier && dla) dhi_r <= wdata;
      if (wr && a_ier && !dla) ier_r <= wdata[3:0];
      kind_r <= rd ? kind_w : 3'h0;
      exp_r <= exp_w;
      quiet_r <= quiet_r && !(wr && a_dat && !dla) && !(wr && a_lfc && wdata[6]);
    end
  end
  sequence break_held;
    lfc_r[ulf_pkg::LFC_BREAK] ##1 lfc_r[ulf_pkg::LFC_BREAK];
  endsequence
  a_lfc_read: assert property (kind_r == 3'h1 |-> rdata == exp_r)
    else $error("line format read back wrong");
  a_div_lo_read: assert property (kind_r == 3'h2 |-> rdata == exp_r)
    else $error("divisor low read wrong");
  a_div_hi_read: assert property (kind_r == 3'h3 |-> rdata == exp_r)
    else $error("divisor high read wrong");
  a_ier_read: assert property (kind_r == 3'h4 |-> rdata == exp_r)
    else $error("enables read wrong");
  a_unmapped_zero: assert property (rd && a_unm |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_break_low: assert property (break_held |-> !serial_tx_line)
    else $error("tx line not low in break");
  a_tx_quiet: assert property (quiet_r |-> serial_tx_line)
    else $error("tx line left idle unasked");
endmodule
bind ulf_line_format ulf_line_format_checker #(.DIV_W(DIV_W)) chk_u (.ref_clk(ref_clk),
  .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line));

// *** dv/ulf_terminal.sv ***
// ****************
// Remote terminal
// ****************
module ulf_terminal (
  input logic ref_clk, // Port clock
  input logic serial_tx_line, // Line from the port
  output logic serial_rx_line // Line to the port
);
  timeunit 1ns;
  timeprecision 100ps;
  initial serial_rx_line = 1'b1;
  task automatic bit_out(input logic v);
    @(posedge ref_clk);
    serial_rx_line <= v;
    repeat (15) @(posedge ref_clk);
  endtask
  // Sixteen cycles a bit, divisor of one assumed
  task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic p,
    input logic s1, input logic s2);
    bit_out(1'b0);
    for (int i = 0; i < nb; i++) bit_out(d[i]);
    if (pe) bit_out(p);
    bit_out(s1);
    bit_out(s2);
    bit_out(1'b1);
  endtask
  // Sampled on falling edges, clear of the port's launch edge
  task automatic recv(input int nb, input int np, output logic [7:0] d, output logic p,
    output int s);
    d = 8'h00;
    p = 1'b0;
    s = 0;
    while (serial_tx_line) @(negedge ref_clk);
    repeat (8) @(negedge ref_clk);
    for (int i = 0; i < nb + np; i++) begin
      repeat (16) @(negedge ref_clk);
      if (i < nb) d[i] = serial_tx_line;
      else p = serial_tx_line;
    end
    repeat (8) @(negedge ref_clk);
    while (serial_tx_line && s < 40) begin
      s++;
      @(negedge ref_clk);
    end
  endtask
endmodule

// *** dv/ulf_line_format_tb.sv ***
// ****************
// Bench top
// ****************
module ulf_line_format_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic serial_rx_line;
  logic serial_tx_line;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2 ref_clk = ~ref_clk;
  ulf_line_format dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .serial_rx_line(serial_rx_line),
    .serial_tx_line(serial_tx_line));
  ulf_terminal p_u (.ref_clk(ref_clk), .serial_tx_line(serial_tx_line),
    .serial_rx_line(serial_rx_line));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask
  function automatic logic epar(input logic [7:0] d, input logic [7:0] f, input int nb);
    logic ones;
    ones = ^(d & (8'hff >> (8 - nb)));
    if (f[5]) return ~f[4];
    return f[4] ? ones : ~ones;
  endfunction
  task automatic t_regs();
    logic [7:0] v;
    rd_reg(8'h0c, v);
    chk8(v, 8'h00);
    rd_reg(8'h14, v);
    chk8(v, 8'h60);
    wr_reg(8'h14, 8'hff);
    rd_reg(8'h14, v);
    chk8(v, 8'h60);
    rd_reg(8'h08, v);
    chk8(v, 8'h00);
    wr_reg(8'h0c, 8'hff);
    rd_reg(8'h0c, v);
    chk8(v, 8'hff);
    wr_reg(8'h0c, 8'h00);
    rd_reg(8'h0c, v);
    chk8(v, 8'h00);
  endtask
  task automatic t_div();
    logic [7:0] v;
    wr_reg(8'h0c, 8'h80);
    wr_reg(8'h00, 8'h01);
    wr_reg(8'h04, 8'h00);
    rd_reg(8'h00, v);
    chk8(v, 8'h01);
    wr_reg(8'h0c, 8'h03);
    wr_reg(8'h04, 8'hfa);
    rd_reg(8'h04, v);
    chk8(v, 8'h0a);
    wr_reg(8'h0c, 8'h83);
    rd_reg(8'h04, v);
    chk8(v, 8'h00);
    wr_reg(8'h0c, 8'h03);
  endtask
  task automatic t_tx();
    logic [15:0] tt[9] = '{16'h0015, 16'h040a, 16'h012a, 16'h0655, 16'h07a5, 16'h0b3c,
      16'h1b3d, 16'h2b00, 16'h3bff};
    logic [7:0] f, d, m, g1, g2;
    logic q1, q2;
    int nb, np, s1, s2, es;
    for (int i = 0; i < 9; i++) begin
      {f, d} = tt[i];
      nb = int'(f[1:0]) + 5;
      np = int'(f[3]);
      m = 8'hff >> (8 - nb);
      es = f[2] ? (f[1:0] == 2'h0 ? 24 : 32) : 16;
      wr_reg(8'h0c, f);
      fork
        begin
          p_u.recv(nb, np, g1, q1, s1);
          p_u.recv(nb, np, g2, q2, s2);
        end
        begin
          wr_reg(8'h00, d);
          wr_reg(8'h00, ~d);
        end
      join
      chk8(g1, d & m);
      if (f[3]) chk8({7'h0, q1}, {7'h0, epar(d, f, nb)});
      // Stop time plus the one idle cycle before the holding reload
      chk8(8'(s1), 8'(es + 1));
      chk8(g2, ~d & m);
      repeat (40) @(posedge ref_clk);
    end
  endtask
  task automatic t_break();
    logic [7:0] v;
    int hi;
    hi = 0;
    wr_reg(8'h0c, 8'h43);
    wr_reg(8'h00, 8'h55);
    repeat (250) begin
      @(negedge ref_clk);
      if (serial_tx_line !== 1'b0) hi++;
    end
    chk8(8'(hi), 8'h00);
    wr_reg(8'h0c, 8'h03);
    repeat (3) @(negedge ref_clk);
    chk8({7'h0, serial_tx_line}, 8'h01);
    rd_reg(8'h14, v);
    chk8(v, 8'h60);
  endtask
  task automatic t_rx();
    logic [31:0] rc[6] = '{32'h1ba50361, 32'h1ba50765, 32'h00150169, 32'h075a0261,
      32'h3bc30361, 32'h2bc30765};
    logic [7:0] f, d, v;
    int nb;
    for (int i = 0; i < 6; i++) begin
      f = rc[i][31:24];
      d = rc[i][23:16];
      nb = int'(f[1:0]) + 5;
      wr_reg(8'h0c, f);
      p_u.send(d, nb, f[3], epar(d, f, nb) ^ rc[i][10], rc[i][9], rc[i][8]);
      rd_reg(8'h14, v);
      chk8(v, rc[i][7:0]);
      rd_reg(8'h00, v);
      chk8(v, d & (8'hff >> (8 - nb)));
      // A low second stop starts a frame of its own; let it finish
      repeat (200) @(posedge ref_clk);
      rd_reg(8'h14, v);
      rd_reg(8'h00, v);
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_div();
    t_tx();
    t_break();
    t_rx();
    test_done();
  end
endmodule
